// [hw/txps_pkg.sv]
// Purpose: Constants for the transmit packet scheduler.
// Assumes: One 100 MHz clock, byte-wide packet buffer writes from the host.
// Notes: Header layout offsets and field positions live here.
// Summary of operation
// - Buffer holds exactly one pending packet, header and payload together.
// - One free-running 32-bit microsecond timer stamps and schedules.
// - Bytes 3 to 6 give start time; emit when timer equals it.
// - Each packet of nonzero length departs immediately or at its programmed timer value.
// - Bytes 0 to 2 give 24-bit channel frequency word, MSB first.
// - Byte 7: radio select, modulation, power above 7 means 20 dBm.
// - Bytes 9 to 15 decode by modulation; byte 8 reserved.
// - Chirp byte 9: CRC enable, coding redundancy, spread factor; byte 10 length.
// - Chirp byte 11: implicit header and bandwidth; bytes 14, 15 reserved.
// - Chirp bytes 12 and 13 give preamble symbols, MSB first.
// - FSK byte 9 gives deviation in kHz, byte 10 payload length.
// - FSK byte 11: length mode, CRC, polynomial, line coding.
// - FSK bytes 12 and 13 give preamble byte count.
// - FSK bytes 14 and 15 give bit rate divider of 32 MHz.
// - Multi-byte fields take the MSB from the lowest position.
// - Header is never emitted; payload starts at byte 16, up to 128.
// - Header configures the transmit path before emission begins.
package txps_pkg;
    localparam int HDR_BYTES = 16;
    localparam int MAX_PAYLOAD = 128;
    localparam int BUF_BYTES = HDR_BYTES + MAX_PAYLOAD;
    localparam int PTR_W = 8;
    localparam logic [7:0] PAYLOAD_BASE = 8'h10;
    localparam int OFS_FREQ = 0;
    localparam int OFS_TIME = 3;
    localparam int OFS_CTRL = 7;
    localparam int OFS_B9 = 9;
    localparam int OFS_LEN = 10;
    localparam int OFS_B11 = 11;
    localparam int OFS_PRE = 12;
    localparam int OFS_RATE = 14;
    localparam int BIT_RADIO = 5;
    localparam int BIT_MOD = 4;
    localparam logic [3:0] PWR_HIGH_ABOVE = 4'h7;
    localparam int BIT_CRC16 = 7;
    localparam int BIT_IMPLICIT = 2;
    localparam int BIT_VARLEN = 0;
    localparam int BIT_FSK_CRC = 1;
    localparam int BIT_CRC_POLY = 4;
    localparam int TICK_NS = 1000;
    localparam int CLK_NS = 10;
    localparam int US_CYCLES = TICK_NS / CLK_NS;
    localparam logic [31:0] TIMER_RESET = 32'h0000_0000;
    localparam logic [7:0] PTR_RESET = 8'h00;
    typedef enum logic [1:0] {TXPS_IDLE, TXPS_WAIT, TXPS_SEND} txps_state_t;
endpackage

// [hw/txps_scheduler.sv]
// Purpose: Holds one packet, decodes its header, emits payload on time.
// Assumes: Host burst writes via wr_ptr_load/wr_en; tx sink gives tx_ready.
// Notes: Decoded fields are held stable from start of wait until done.
`timescale 1ns/1ps
module txps_scheduler
    import txps_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_ptr_load,
    input wire logic [7:0] wr_ptr_value,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic tx_go,
    input wire logic tx_immediate,
    input wire logic tx_ready,
    output logic buf_free,
    output logic tx_busy,
    output logic [31:0] timer_us,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    output logic [23:0] chan_freq,
    output logic [31:0] start_time,
    output logic radio_sel,
    output logic mod_fsk,
    output logic [3:0] power_code,
    output logic power_high,
    output logic [7:0] payload_len,
    output logic crc16_en,
    output logic [2:0] coding_redundancy_field,
    output logic [3:0] spread_factor_field,
    output logic implicit_hdr,
    output logic [1:0] bandwidth_sel,
    output logic [15:0] preamble_len,
    output logic [7:0] freq_dev_khz,
    output logic var_length,
    output logic fsk_crc_en,
    output logic crc_polynomial_select,
    output logic [1:0] line_balance_coding,
    output logic [15:0] bitrate_div
);
    logic [7:0] buffer [0:BUF_BYTES-1];
    logic [7:0] wptr;
    logic [7:0] rptr;
    logic [7:0] remain;
    logic [6:0] us_div;
    txps_state_t state;
    txps_state_t next_state;
    logic us_tick;
    logic time_hit;
    logic go_ok;
    logic send_beat;
    logic last_beat;
    logic fsk_mode;
    logic len_zero;
    logic load_chirp;
    logic load_fsk;
    logic [7:0] rd_index;
    logic [23:0] hdr_freq;
    logic [31:0] hdr_time;
    logic [7:0] hdr_ctrl;
    logic [7:0] hdr_b9;
    logic [7:0] hdr_len;
    logic [7:0] hdr_b11;
    logic [15:0] hdr_pre;
    logic [15:0] hdr_rate;

    assign us_tick = (us_div == 7'(US_CYCLES - 1));
    assign go_ok = tx_go && (state == TXPS_IDLE);
    // Equality only: a start time already passed waits a full wrap.
    assign time_hit = (timer_us == start_time);
    assign send_beat = (state == TXPS_SEND) && tx_ready;
    assign last_beat = send_beat && (remain == 8'h01);
    assign fsk_mode = buffer[OFS_CTRL][BIT_MOD];
    assign buf_free = (state == TXPS_IDLE);
    assign tx_busy = (state != TXPS_IDLE);
    assign tx_valid = (state == TXPS_SEND);
    assign tx_last = tx_valid && (remain == 8'h01);

    // Multi-byte fields are assembled with the lowest position on top.
    assign hdr_freq = {buffer[OFS_FREQ], buffer[OFS_FREQ+1],
        buffer[OFS_FREQ+2]};
    assign hdr_time = {buffer[OFS_TIME], buffer[OFS_TIME+1],
        buffer[OFS_TIME+2], buffer[OFS_TIME+3]};
    assign hdr_ctrl = buffer[OFS_CTRL];
    assign hdr_b9 = buffer[OFS_B9];
    assign hdr_len = buffer[OFS_LEN];
    assign hdr_b11 = buffer[OFS_B11];
    assign hdr_pre = {buffer[OFS_PRE], buffer[OFS_PRE+1]};
    assign hdr_rate = {buffer[OFS_RATE], buffer[OFS_RATE+1]};
    assign len_zero = (hdr_len == 8'h00);
    assign load_chirp = go_ok && !fsk_mode;
    assign load_fsk = go_ok && fsk_mode;
    // The first payload byte is fetched on go, so an immediate start
    // never shows a byte left over from the previous packet.
    assign rd_index = go_ok ? PAYLOAD_BASE :
        (send_beat && !last_beat) ? rptr + 8'h01 : rptr;

    // Writes are refused while a packet is pending; the host waits.
    always_ff @(posedge clk)
    begin
        if (wr_en && state == TXPS_IDLE && wptr < 8'(BUF_BYTES))
        begin
            buffer[wptr] <= wr_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wptr <= PTR_RESET;
        end
        else if (wr_ptr_load)
        begin
            wptr <= wr_ptr_value;
        end
        else if (wr_en && state == TXPS_IDLE)
        begin
            wptr <= wptr + 8'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            us_div <= 7'h00;
            timer_us <= TIMER_RESET;
        end
        else if (us_tick)
        begin
            us_div <= 7'h00;
            timer_us <= timer_us + 32'h1;
        end
        else
        begin
            us_div <= us_div + 7'h01;
        end
    end

    always_comb
    begin
        next_state = state;
        unique case (state)
            TXPS_IDLE:
            begin
                if (go_ok && len_zero)
                    next_state = TXPS_IDLE;
                else if (go_ok && tx_immediate)
                    next_state = TXPS_SEND;
                else if (go_ok)
                    next_state = TXPS_WAIT;
            end
            TXPS_WAIT:
            begin
                if (time_hit)
                    next_state = TXPS_SEND;
            end
            TXPS_SEND:
            begin
                if (last_beat)
                    next_state = TXPS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            state <= TXPS_IDLE;
        else
            state <= next_state;
    end

    // Header is latched on go so the transmit path is set before emission.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            chan_freq <= 24'h0;
        else if (go_ok)
            chan_freq <= hdr_freq;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            start_time <= 32'h0;
        else if (go_ok)
            start_time <= hdr_time;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            radio_sel <= 1'b0;
        else if (go_ok)
            radio_sel <= hdr_ctrl[BIT_RADIO];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            mod_fsk <= 1'b0;
        else if (go_ok)
            mod_fsk <= fsk_mode;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            power_code <= 4'h0;
        else if (go_ok)
            power_code <= hdr_ctrl[3:0];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            power_high <= 1'b0;
        else if (go_ok)
            power_high <= hdr_ctrl[3:0] > PWR_HIGH_ABOVE;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            payload_len <= 8'h0;
        else if (go_ok)
            payload_len <= hdr_len;
    end

    // Modem-specific fields; the unused modem's fields are cleared.
    always_ff @(posedge clk)
    begin
        if (!rst_n || load_fsk)
            crc16_en <= 1'b0;
        else if (load_chirp)
            crc16_en <= hdr_b9[BIT_CRC16];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || load_fsk)
            coding_redundancy_field <= 3'h0;
        else if (load_chirp)
            coding_redundancy_field <= hdr_b9[6:4];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || load_fsk)
            spread_factor_field <= 4'h0;
        else if (load_chirp)
            spread_factor_field <= hdr_b9[3:0];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || load_fsk)
            implicit_hdr <= 1'b0;
        else if (load_chirp)
            implicit_hdr <= hdr_b11[BIT_IMPLICIT];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || load_fsk)
            bandwidth_sel <= 2'h0;
        else if (load_chirp)
            bandwidth_sel <= hdr_b11[1:0];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || load_chirp)
            freq_dev_khz <= 8'h0;
        else if (load_fsk)
            freq_dev_khz <= hdr_b9;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || load_chirp)
            var_length <= 1'b0;
        else if (load_fsk)
            var_length <= hdr_b11[BIT_VARLEN];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || load_chirp)
            fsk_crc_en <= 1'b0;
        else if (load_fsk)
            fsk_crc_en <= hdr_b11[BIT_FSK_CRC];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || load_chirp)
            crc_polynomial_select <= 1'b0;
        else if (load_fsk)
            crc_polynomial_select <= hdr_b11[BIT_CRC_POLY];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || load_chirp)
            line_balance_coding <= 2'h0;
        else if (load_fsk)
            line_balance_coding <= hdr_b11[3:2];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || load_chirp)
            bitrate_div <= 16'h0;
        else if (load_fsk)
            bitrate_div <= hdr_rate;
    end

    // The preamble count is shared by both modems.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            preamble_len <= 16'h0;
        else if (go_ok)
            preamble_len <= hdr_pre;
    end

    // Read pointer starts at the payload; header bytes never go out.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rptr <= PAYLOAD_BASE;
            remain <= 8'h0;
        end
        else if (go_ok)
        begin
            rptr <= PAYLOAD_BASE;
            remain <= (buffer[OFS_LEN] > 8'(MAX_PAYLOAD)) ?
                8'(MAX_PAYLOAD) : buffer[OFS_LEN];
        end
        else if (send_beat)
        begin
            rptr <= rptr + 8'h01;
            remain <= remain - 8'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            tx_data <= 8'h0;
        else
            tx_data <= buffer[rd_index];
    end
endmodule

// [sim/txps_assertions.sv]
// Purpose: Port timing checks for the transmit packet scheduler.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every scheduler instance.
`timescale 1ns/1ps
module txps_assertions
    import txps_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tx_ready,
    input wire logic buf_free,
    input wire logic tx_busy,
    input wire logic [31:0] timer_us,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic [23:0] chan_freq,
    input wire logic [31:0] start_time,
    input wire logic mod_fsk,
    input wire logic [3:0] power_code,
    input wire logic power_high,
    input wire logic [2:0] coding_redundancy_field,
    input wire logic [7:0] freq_dev_khz,
    input wire logic [15:0] bitrate_div
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence last_beat;
        tx_valid && tx_ready && tx_last;
    endsequence
    sequence held_busy;
        tx_busy ##1 tx_busy;
    endsequence
    free_busy_a: assert property (buf_free != tx_busy)
        else $error("buf_free equals tx_busy");
    tick_step_a: assert property ($changed(timer_us) |->
        timer_us == $past(timer_us) + 32'h1)
        else $error("timer jumped");
    tick_rate_a: assert property (1 |-> ##[1:100] $changed(timer_us))
        else $error("timer stalled");
    stream_hold_a: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_data))
        else $error("byte dropped under stall");
    cfg_hold_a: assert property (held_busy |->
        $stable({chan_freq, start_time, bitrate_div}))
        else $error("config moved while busy");
    power_map_a: assert property (power_high == (power_code > 4'h7))
        else $error("power level wrong");
    modem_zero_a: assert property (mod_fsk ?
        coding_redundancy_field == 3'h0 :
        freq_dev_khz == 8'h00 && bitrate_div == 16'h0000)
        else $error("other modem fields set");
    release_a: assert property (last_beat |=> buf_free && !tx_valid)
        else $error("buffer not released");
    on_time_a: assert property (tx_busy && !tx_valid
        |-> if (timer_us == start_time) (##1 tx_valid) else (##1 !tx_valid))
        else $error("start time missed");
endmodule
bind txps_scheduler txps_assertions chk_u (.clk, .rst_n, .tx_ready,
    .buf_free, .tx_busy, .timer_us, .tx_valid, .tx_data, .tx_last,
    .chan_freq, .start_time, .mod_fsk, .power_code, .power_high,
    .coding_redundancy_field, .freq_dev_khz, .bitrate_div);

// [sim/txps_sink.sv]
// Purpose: Payload sink model that stalls in a changing pattern.
// Assumes: Shares the scheduler clock.
// Notes: Stalls exercise the hold of tx_data under back-pressure.
`timescale 1ns/1ps
module txps_sink
(
    input wire logic clk,
    input wire logic rst_n,
    output logic tx_ready
);
    logic [4:0] lfsr;
    always_ff @(negedge clk)
        lfsr <= rst_n ? {lfsr[3:0], lfsr[4] ^ lfsr[2]} : 5'h01;
    assign tx_ready = lfsr[0] | lfsr[3];
endmodule

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the transmit packet scheduler.
// Assumes: Host writes at the falling edge; sink stalls at random.
// Notes: Covers chirp, FSK, deferred start and refused writes.
`timescale 1ns/1ps
module tb_top
    import txps_pkg::*;
();
    logic clk, rst_n, wr_ptr_load, wr_en, tx_go, tx_immediate;
    logic [7:0] wr_ptr_value, wr_data;
    wire tx_ready, buf_free, tx_busy, tx_valid, tx_last, radio_sel;
    wire mod_fsk, power_high, crc16_en, implicit_hdr, var_length;
    wire fsk_crc_en, crc_polynomial_select;
    wire [31:0] timer_us, start_time;
    wire [23:0] chan_freq;
    wire [7:0] tx_data, payload_len, freq_dev_khz;
    wire [3:0] power_code, spread_factor_field;
    wire [2:0] coding_redundancy_field;
    wire [1:0] bandwidth_sel, line_balance_coding;
    wire [15:0] preamble_len, bitrate_div;
    int failures = 0;
    int n_tests = 0;
    integer seed = 59;
    logic [7:0] h [0:143];
    logic [7:0] q [$];
    logic [8:0] e;
    txps_scheduler dut_u (.clk, .rst_n, .wr_ptr_load, .wr_ptr_value,
        .wr_en, .wr_data, .tx_go, .tx_immediate, .tx_ready, .buf_free,
        .tx_busy, .timer_us, .tx_valid, .tx_data, .tx_last, .chan_freq,
        .start_time, .radio_sel, .mod_fsk, .power_code, .power_high,
        .payload_len, .crc16_en, .coding_redundancy_field,
        .spread_factor_field, .implicit_hdr, .bandwidth_sel,
        .preamble_len, .freq_dev_khz, .var_length, .fsk_crc_en,
        .crc_polynomial_select, .line_balance_coding, .bitrate_div);
    txps_sink sink_u (.clk(clk), .rst_n(rst_n), .tx_ready(tx_ready));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task end_sim();
        $display("failures %0d n_tests %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk_field(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task chk_byte(input logic [8:0] got, input logic [8:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // The start time is set two ticks ahead, so the wait always spans
    // the refused write and go issued below.
    task send(input logic fsk, input logic imm, input int len);
        int i;
        for (i = 0; i < 16 + len; i++)
            h[i] = $random(seed);
        h[7][4] = fsk;
        h[10] = len[7:0];
        @(negedge clk);
        {h[3], h[4], h[5], h[6]} = timer_us + 32'h2;
        wr_ptr_load = 1'b1;
        wr_ptr_value = 8'h00;
        for (i = 0; i < 16 + len; i++)
        begin
            @(negedge clk);
            wr_ptr_load = 1'b0;
            wr_en = 1'b1;
            wr_data = h[i];
            if (i >= 16)
                q.push_back(h[i]);
        end
        @(negedge clk);
        wr_en = 1'b0;
        tx_go = 1'b1;
        tx_immediate = imm;
        @(negedge clk);
        tx_go = 1'b0;
        if (!imm)
        begin
            wr_ptr_load = 1'b1;
            wr_ptr_value = PAYLOAD_BASE;
            @(negedge clk);
            wr_ptr_load = 1'b0;
            wr_en = 1'b1;
            wr_data = ~h[16];
            tx_go = 1'b1;
            @(negedge clk);
            wr_en = 1'b0;
            tx_go = 1'b0;
        end
        chk_field({chan_freq, start_time},
            {h[0], h[1], h[2], h[3], h[4], h[5], h[6]});
        chk_field({radio_sel, mod_fsk, power_code, power_high,
            payload_len}, {h[7][5:0], h[7][3:0] > 4'h7, h[10]});
        chk_field({crc16_en, coding_redundancy_field,
            spread_factor_field, implicit_hdr, bandwidth_sel},
            fsk ? 11'h000 : {h[9], h[11][2:0]});
        chk_field({freq_dev_khz, var_length, fsk_crc_en,
            line_balance_coding, crc_polynomial_select}, fsk ?
            {h[9], h[11][0], h[11][1], h[11][3:2], h[11][4]} : 13'h0);
        chk_field({preamble_len, bitrate_div},
            {h[12], h[13], fsk ? {h[14], h[15]} : 16'h0000});
        for (i = 0; i < 2000 && buf_free !== 1'b1; i++)
            @(negedge clk);
        if (buf_free !== 1'b1)
        begin
            failures++;
            end_sim();
        end
        chk_field(q.size(), 0);
    endtask
    always @(posedge clk)
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
        begin
            e = {q.size() == 1, q.size() > 0 ? q[0] : 8'h00};
            if (q.size() > 0)
                void'(q.pop_front());
            chk_byte({tx_last, tx_data}, e);
        end
    initial
    begin
        rst_n = 1'b0;
        wr_ptr_load = 1'b0;
        wr_en = 1'b0;
        tx_go = 1'b0;
        tx_immediate = 1'b0;
        wr_ptr_value = 8'h00;
        wr_data = 8'h00;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        chk_field({buf_free, tx_valid, timer_us}, 34'h200000000);
        send(1'b0, 1'b1, 128);
        send(1'b1, 1'b0, 1 + ($random(seed) & 63));
        send(1'b0, 1'b0, 3);
        send(1'b1, 1'b1, 1);
        send(1'b1, 1'b1, 0);
        end_sim();
    end
endmodule
